//--- rtl/aas_top.sv
`timescale 1ns/1ps
module aas_top
    import aas_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    // Conversion results from the core
    input  wire logic        conv_valid_i,
    input  wire logic [23:0] conv_data_i,
    output logic             conv_ready_o,
    // Serial link pins
    input  wire logic        sck_i,
    input  wire logic        read_select_or_serial_in_i,
    input  wire logic        chain_i,
    output logic             sdo_o,
    output logic             sdo_oe_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] io;
        logic [ACC_W-1:0]  acc;
        logic [NS_W-1:0]   n;
        logic [4:0]        sck_cnt;
        aas_rd_type        rd;
        logic              sck_prev;
        logic              ctrl_en;
        logic              ack;
        logic [31:0]       dat;
        logic              sdo;
        logic              oe;
    } aas_top_st_type;

    localparam aas_top_st_type ST_RST = '{
        rd:      RD_IDLE,
        ctrl_en: CTRL_EN_RST,
        default: '0
    };

    aas_top_st_type q;
    aas_top_st_type d;

    // ----------------------------------------
    // Pin synchronisers and conversion buffer
    // ----------------------------------------
    logic [2:0]       lk_s;
    logic             sck_s;
    logic             sel_s;
    logic             chain_s;
    logic             pop_valid;
    logic             pop_ready;
    logic [RES_W-1:0] pop_data;

    // Select idles high: reset must not look like a select
    aas_sync #(
        .W       (3),
        .RST_VAL (3'h2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({chain_i, read_select_or_serial_in_i, sck_i}),
        .sync_o     (lk_s)
    );

    assign sck_s   = lk_s[0];
    assign sel_s   = lk_s[1];
    assign chain_s = lk_s[2];

    // Two entries ride out a shift-clock edge that stalls the averager
    aas_buf #(
        .W (RES_W)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (conv_valid_i),
        .in_data_i   (conv_data_i),
        .in_ready_o  (conv_ready_o),
        .out_valid_o (pop_valid),
        .out_data_o  (pop_data),
        .out_ready_i (pop_ready)
    );

    // ----------------------------------------
    // Averaging arithmetic
    // ----------------------------------------
    logic              sck_rise;
    logic              shift_en;
    logic              conv_fire;
    logic              read_ends;
    logic [ACC_W:0]    acc_sum;
    logic [ACC_W-1:0]  acc_new;
    logic [NS_W-1:0]   n_new;
    logic [4:0]        m_log;
    logic [ACC_W-1:0]  avg_full;
    logic [RES_W-1:0]  avg;
    logic [CNT_W-1:0]  cnt_f;
    logic [WORD_W-1:0] load_word;

    function automatic logic [4:0] m_log_of(input logic [NS_W-1:0] n);
        logic [4:0] k;
        k = M_LOG_MAX;
        for (int i = 16; i >= 0; i--) begin
            if ((17'h00001 << i) >= n) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction

    assign sck_rise  = sck_s & ~q.sck_prev;
    // Normal mode with select high drops shift clock edges
    assign shift_en  = sck_rise & (chain_s | ~sel_s);
    // Never pop on a shift edge, so a read start and a sum never collide
    assign pop_ready = q.ctrl_en & ~sck_rise;
    assign conv_fire = pop_valid & pop_ready;
    assign read_ends = (q.sck_cnt == 5'h00)
                     | (q.sck_cnt == SCK_HOLD_LIMIT);

    // Sum saturates rather than wraps on very long averages
    assign acc_sum  = {1'b0, q.acc} + {18'h00000, pop_data};
    assign acc_new  = acc_sum[ACC_W] ? {ACC_W{1'b1}} : acc_sum[ACC_W-1:0];
    assign n_new    = (q.n == NS_SAT) ? q.n : 17'(q.n + 17'h00001);
    assign m_log    = m_log_of(n_new);
    assign avg_full = acc_new >> m_log;
    assign avg      = (|avg_full[ACC_W-1:RES_W]) ? {RES_W{1'b1}}
                                                 : avg_full[RES_W-1:0];
    assign cnt_f    = (n_new > NS_FULL) ? {CNT_W{1'b1}}
                                        : 16'(n_new - 17'h00001);
    assign load_word = {avg, cnt_f};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d          = q;
        d.sck_prev = sck_s;
        if (shift_en) begin
            if (q.rd == RD_IDLE) begin
                d.rd  = RD_ACTIVE;
                d.acc = '0;
                d.n   = '0;
            end
            // Upstream bit enters at the bottom, forty edges to the top
            d.io = {q.io[WORD_W-2:0], chain_s & sel_s};
            if (q.sck_cnt != SCK_HOLD_LIMIT) begin
                d.sck_cnt = 5'(q.sck_cnt + 5'h01);
            end
        end
        if (conv_fire) begin
            d.acc     = acc_new;
            d.n       = n_new;
            d.sck_cnt = '0;
            if (read_ends) begin
                d.rd = RD_IDLE;
                d.io = load_word;
            end
        end
        d.sdo = d.io[WORD_W-1];
        d.oe  = chain_s | ~sel_s;
        d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        d.dat = '0;
        if (d.ack && !wb_we_i) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    d.dat[CTRL_EN_BIT] = q.ctrl_en;
                end
                OFS_STATUS: begin
                    d.dat[STAT_ACTIVE_BIT] = (q.rd == RD_ACTIVE);
                    d.dat[STAT_CHAIN_BIT]  = chain_s;
                    d.dat[STAT_SEL_BIT]    = sel_s;
                    d.dat[STAT_SCK_LSB +: 5] = q.sck_cnt;
                end
                OFS_RESULT: begin
                    d.dat[RES_W-1:0] = q.io[WORD_W-1:CNT_W];
                end
                OFS_COUNT: begin
                    d.dat[CNT_W-1:0] = q.io[CNT_W-1:0];
                end
                default: begin
                    d.dat = '0;
                end
            endcase
        end
        // Write lands at the edge where the master sees ack high
        if (q.ack && wb_cyc_i && wb_stb_i && wb_we_i
                && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
            d.ctrl_en = wb_dat_i[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign sdo_o    = q.sdo;
    assign sdo_oe_o = q.oe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_reload;
        conv_fire && read_ends;
    endsequence

    sequence s_hold;
        conv_fire && !read_ends;
    endsequence

    AST_WORD_LOAD: assert property (
        s_reload |=> q.io == $past(load_word) ##1 sdo_o == q.io[39])
        else $error("output word not loaded on read end");

    AST_CNT_MINUS_ONE: assert property (
        s_reload and (q.n == 17'h00000) |=> q.io[15:0] == 16'h0000)
        else $error("single sample count not zero");

    AST_CNT_SAT: assert property (
        s_reload and (q.n >= NS_FULL) |=> q.io[15:0] == 16'hFFFF)
        else $error("count field did not saturate");

    AST_SINGLE_AVG: assert property (
        s_reload and (q.n == 17'h00000 && q.acc == '0)
        |=> q.io[39:16] == $past(pop_data))
        else $error("single sample average wrong");

    AST_SEL_FLOAT: assert property (
        !chain_s && sel_s |=> !sdo_oe_o)
        else $error("output driven while deselected");

    AST_SEL_DRIVE: assert property (
        !chain_s && !sel_s |=> sdo_oe_o)
        else $error("output floating while selected");

    AST_SCK_IGNORED: assert property (
        !chain_s && sel_s && sck_rise |=> $stable(q.io) || $past(conv_fire))
        else $error("deselected device shifted");

    AST_CHAIN_DRIVE: assert property (
        chain_s |=> sdo_oe_o)
        else $error("chain mode output not driven");

    AST_CHAIN_CAPTURE: assert property (
        shift_en && chain_s |=> q.io[0] == $past(sel_s) ##1 sdo_o == q.io[39])
        else $error("upstream bit not captured");

    AST_ONE_BIT: assert property (
        shift_en |=> q.io[39:1] == $past(q.io[38:0]))
        else $error("shift did not move one bit");

    AST_HOLD: assert property (
        s_hold |=> $stable(q.io) && q.rd == RD_ACTIVE)
        else $error("output word changed during distributed read");

    AST_RESTART: assert property (
        shift_en && q.rd == RD_IDLE |=> q.n == '0 && q.rd == RD_ACTIVE)
        else $error("averager not restarted at read start");

    AST_READ_END: assert property (
        s_reload |=> q.rd == RD_IDLE && q.sck_cnt == 5'h00)
        else $error("read not ended");

    // ----------------------------------------
    // Read-out checks
    // ----------------------------------------
    AST_SCK_CNT_CAP: assert property (
        q.sck_cnt <= SCK_HOLD_LIMIT)
        else $error("shift pulse count passed its cap");

    AST_TOP_BIT: assert property (
        s_reload |=> sdo_o == $past(load_word[WORD_W-1]))
        else $error("result top bit not shown after reload");

    AST_SELECT_MSB: assert property (
        $fell(sel_s) && !chain_s |=> sdo_oe_o && sdo_o == q.io[WORD_W-1])
        else $error("word top bit not shown on select");

    AST_NO_POP_ON_SHIFT: assert property (
        sck_rise |-> !conv_fire)
        else $error("conversion taken on a shift edge");

    AST_ACC_RESTART: assert property (
        shift_en && q.rd == RD_IDLE |=> q.acc == '0)
        else $error("sum not cleared at read start");

    AST_N_SAT: assert property (
        conv_fire && q.n == NS_SAT |=> q.n == NS_SAT)
        else $error("sample counter wrapped");

    AST_NORMAL_FILL: assert property (
        shift_en && !chain_s |=> q.io[0] == 1'b0)
        else $error("normal mode shifted in a one");

    AST_CHAIN_SHIFTS: assert property (
        chain_s && sck_rise |-> shift_en)
        else $error("chain mode dropped a shift edge");

    AST_AVG_POW2: assert property (
        s_reload and (q.n == 17'h00001)
        |=> q.io[WORD_W-1:CNT_W] == $past(acc_new[RES_W:1]))
        else $error("two sample average not halved");

    AST_CNT_FIELD: assert property (
        s_reload and (q.n < NS_FULL)
        |=> q.io[CNT_W-1:0] == $past(q.n[CNT_W-1:0]))
        else $error("count field not samples minus one");

endmodule

//--- rtl/aas_pkg.sv
package aas_pkg;

    // ----------------------------------------
    // Word layout
    // ----------------------------------------
    localparam int RES_W  = 24;
    localparam int CNT_W  = 16;
    localparam int WORD_W = 40;
    localparam int ACC_W  = 41;
    localparam int NS_W   = 17;

    // ----------------------------------------
    // Read window limits and divisor cap
    // ----------------------------------------
    localparam logic [4:0]  SCK_HOLD_LIMIT = 5'h14;
    localparam logic [4:0]  M_LOG_MAX      = 5'h10;
    localparam logic [16:0] NS_FULL        = 17'h10000;
    localparam logic [16:0] NS_SAT         = 17'h1FFFF;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_COUNT  = 8'h0C;
    localparam int         CTRL_EN_BIT     = 0;
    localparam logic       CTRL_EN_RST     = 1'b1;
    localparam int         STAT_ACTIVE_BIT = 0;
    localparam int         STAT_CHAIN_BIT  = 1;
    localparam int         STAT_SEL_BIT    = 2;
    localparam int         STAT_SCK_LSB    = 8;

    // ----------------------------------------
    // Read state
    // ----------------------------------------
    typedef enum logic [1:0] {
        RD_IDLE   = 2'b01,
        RD_ACTIVE = 2'b10
    } aas_rd_type;

endpackage

//--- rtl/aas_sync.sv
`timescale 1ns/1ps
module aas_sync
    import aas_pkg::*;
#(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // Levels from outside the clock domain
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } aas_sync_st_type;

    aas_sync_st_type q;
    aas_sync_st_type d;

    always_comb begin
        d        = q;
        d.meta   = async_i;
        d.stable = q.meta;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stable;

endmodule

//--- rtl/aas_buf.sv
`timescale 1ns/1ps
module aas_buf
    import aas_pkg::*;
#(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // Filling side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Draining side
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
        logic              full;
        logic              empty;
        logic              rdy;
    } aas_buf_st_type;

    localparam aas_buf_st_type ST_RST = '{
        empty:   1'b1,
        rdy:     1'b1,
        default: '0
    };

    aas_buf_st_type q;
    aas_buf_st_type d;
    logic           push;
    logic           pop;

    assign push = in_valid_i & ~q.full;
    assign pop  = out_ready_i & ~q.empty;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_i;
            d.wp        = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt   = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
        d.full  = (d.cnt == 2'h2);
        d.empty = (d.cnt == 2'h0);
        d.rdy   = (d.cnt != 2'h2);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign in_ready_o  = q.rdy;
    assign out_valid_o = ~q.empty;
    assign out_data_o  = q.mem[q.rp];

endmodule

//--- tb/aas_host_model.sv
`timescale 1ns/1ps
module aas_host_model (
    // Link pins toward the device
    output logic      sck_o,
    output logic      sel_o,
    output logic      chain_o,
    input  wire logic sdo_i
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        sck_o   = 1'b0;
        sel_o   = 1'b1;
        chain_o = 1'b0;
    end

    task automatic set_pins(input logic sel, input logic chain);
        sel_o   = sel;
        chain_o = chain;
    endtask

    // ----------------------------------------
    // Frames: clock stands low between them
    // ----------------------------------------
    // Upstream bit is set half a period before each rise
    task automatic shift(input int n, input logic [39:0] up,
                         output logic [79:0] got);
        got = '0;
        for (int k = 0; k < n; k++) begin
            if (chain_o)
                sel_o = (k < 40) ? up[39-k] : ~sel_o;
            #160 sck_o = 1'b1;
            got = {got[78:0], sdo_i};
            #160 sck_o = 1'b0;
        end
    endtask
endmodule

//--- tb/aas_top_tb.sv
`timescale 1ns/1ps
module aas_top_tb;
    import aas_pkg::*;

    logic        core_clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic        conv_valid_i;
    logic [23:0] conv_data_i;
    logic        conv_ready_o;
    logic        sck;
    logic        sel;
    logic        chain;
    logic        sdo_o;
    logic        sdo_oe_o;
    wire         sdo_line;
    logic [31:0] rd;
    logic [79:0] got;
    logic [7:0]  head;
    int          fails;
    int          tests_run;
    int          k;
    int          t;

    // Nobody holds the line when the device lets go
    assign sdo_line = sdo_oe_o ? sdo_o : 1'bz;

    aas_top aas_top_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
        .conv_ready_o(conv_ready_o), .sck_i(sck),
        .read_select_or_serial_in_i(sel), .chain_i(chain),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o)
    );

    aas_host_model aas_host_model_inst (
        .sck_o(sck), .sel_o(sel), .chain_o(chain), .sdo_i(sdo_line)
    );

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic stop_test();
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [79:0] exp,
                         input logic [79:0] seen);
        tests_run++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 50) begin
            fails++;
            stop_test();
        end
    endtask

    // Drain time per the hand-over walk, with margin
    task automatic push(input logic [23:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        conv_valid_i <= 1'b1;
        conv_data_i  <= d;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (conv_ready_o !== 1'b1 && n < 50);
        conv_valid_i <= 1'b0;
        repeat (8) @(negedge core_clk_i);
        if (n >= 50) begin
            fails++;
            stop_test();
        end
    endtask

    // Pins pass two sync flops before they act
    task automatic pins(input logic s, input logic c);
        aas_host_model_inst.set_pins(s, c);
        repeat (8) @(negedge core_clk_i);
    endtask

    task automatic frame(input int n, input logic [39:0] up);
        aas_host_model_inst.shift(n, up, got);
    endtask

    task automatic reg_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0, rd);
        check("register", {48'h0, exp}, {48'h0, rd});
    endtask

    task automatic read_all(input logic [39:0] exp);
        pins(1'b0, 1'b0);
        check("first bit", exp[39], sdo_line);
        frame(40, 40'h0);
        pins(1'b1, 1'b0);
        check("word", exp, got[39:0]);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial begin
        rst_i        = 1'b1;
        wb_cyc_i     = 1'b0;
        wb_stb_i     = 1'b0;
        wb_we_i      = 1'b0;
        wb_adr_i     = 8'h00;
        wb_sel_i     = 4'hF;
        wb_dat_i     = 32'h0;
        conv_valid_i = 1'b0;
        conv_data_i  = 24'h0;
        fails        = 0;
        tests_run    = 0;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        reg_chk(OFS_CTRL, {31'h0, CTRL_EN_RST});
        reg_chk(OFS_STATUS, 32'h4);
        wb_xfer(1'b1, 8'h10, 32'hFFFFFFFF, rd);
        reg_chk(8'h10, 32'h0);
        // Byte lane zero off: the enable must not move
        wb_sel_i <= 4'hE;
        wb_xfer(1'b1, OFS_CTRL, 32'h0, rd);
        wb_sel_i <= 4'hF;
        reg_chk(OFS_CTRL, 32'h1);
        push(24'hA5C3F1);
        reg_chk(OFS_COUNT, 32'h0);
        frame(5, 40'h0);
        check("float", 1'b0, sdo_oe_o);
        read_all({24'hA5C3F1, 16'h0000});
        reg_chk(OFS_STATUS, 32'h1405);
        // Paused draining fills the two-entry buffer
        push(24'h200001);
        wb_xfer(1'b1, OFS_CTRL, 32'h0, rd);
        push(24'h400003);
        push(24'h600005);
        check("full", 1'b0, conv_ready_o);
        wb_xfer(1'b1, OFS_CTRL, 32'h1, rd);
        repeat (8) @(negedge core_clk_i);
        check("empty", 1'b1, conv_ready_o);
        reg_chk(OFS_RESULT, 32'h300002);
        reg_chk(OFS_COUNT, 32'h2);
        // Word read across a conversion stays intact
        pins(1'b0, 1'b0);
        frame(8, 40'h0);
        head = got[7:0];
        push(24'h0000FF);
        frame(32, 40'h0);
        check("split", {24'h300002, 16'h2}, {head, got[31:0]});
        pins(1'b1, 1'b0);
        push(24'h000101);
        read_all({24'h000100, 16'h0001});
        // One word taken per free cycle
        @(posedge core_clk_i);
        conv_data_i  <= 24'h000010;
        conv_valid_i <= 1'b1;
        k = 0;
        t = 0;
        while (k < 65537 && t < 68000) begin
            @(negedge core_clk_i);
            if (conv_ready_o === 1'b1)
                k++;
            t++;
            @(posedge core_clk_i);
        end
        conv_valid_i <= 1'b0;
        check("stream", 1'b1, t < 68000);
        repeat (8) @(negedge core_clk_i);
        reg_chk(OFS_RESULT, 32'h10);
        reg_chk(OFS_COUNT, 32'hFFFF);
        pins(1'b1, 1'b1);
        check("chain drive", 1'b1, sdo_oe_o);
        frame(80, 40'hC35A960F1E);
        check("chain", {24'h10, 16'hFFFF, 40'hC35A960F1E}, got);
        push(24'h7F0001);
        reg_chk(OFS_RESULT, 32'h7F0001);
        reg_chk(OFS_COUNT, 32'h0);
        stop_test();
    end
endmodule
